/* src/cmc_consts.vh */
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

// Register byte addresses
`define CMC_ADDR_CTRL      12'h000
`define CMC_ADDR_CFG2      12'h004
`define CMC_ADDR_STATUS    12'h008
`define CMC_ADDR_PROT      12'h00C

// Mode and control register fields
`define CMC_IDLE_STOP_BIT  13
`define CMC_ABORT_ALL_BIT  12
`define CMC_REQ_HI         10
`define CMC_REQ_LO         8
`define CMC_CUR_HI         7
`define CMC_CUR_LO         5
`define CMC_CAPLINK_BIT    3
`define CMC_WINDOW_BIT     0
`define CMC_CTRL_WMASK     16'h370F

// Second configuration register field
`define CMC_WAKE_FILT_BIT  14

// Status register fields
`define CMC_ST_WAKE_BIT    0
`define CMC_ST_ABORTED_BIT 1
`define CMC_ST_TX_REQUEST_FLAG_BIT   2
`define CMC_ST_IDLE_BIT    3
`define CMC_ST_BUSY_BIT    4
`define CMC_ST_HALT_BIT    5
`define CMC_ST_OVLD_LO     6
`define CMC_ST_OVLD_HI     7

// Mode codes
`define CMC_MODE_NORMAL    3'h0
`define CMC_MODE_DISABLE   3'h1
`define CMC_MODE_LOOPBACK  3'h2
`define CMC_MODE_LISTEN    3'h3
`define CMC_MODE_CONFIG    3'h4
`define CMC_MODE_LISTALL   3'h7

// Timing
`define CMC_IDLE_BITS      11
`define CMC_MAX_OVERLOADS  2
`define CMC_BASE_ID_BITS   11
`define CMC_EXT_ID_BITS    18

`endif

/* src/cmc_mode_ctrl.v */
// Design decisions made here: the register addresses and the APB register port.
`include "cmc_consts.vh"

module cmc_mode_ctrl
#(
  parameter WAKE_FILT_LEN = 8
)
(
  input  wire        i_core_clk,
  input  wire        i_resetn,
  input  wire        i_clk_en,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  // Protocol engine side
  input  wire        i_bit_tick,
  input  wire        i_rx_bit,
  input  wire        i_eng_tx_bit,
  input  wire        i_tx_busy,
  input  wire        i_tx_pending,
  input  wire        i_tx_start,
  input  wire        i_all_aborted,
  input  wire        i_rx_msg_done,
  input  wire        i_rx_error,
  input  wire        i_ifs_dominant,
  input  wire        i_rx_not_ready,
  input  wire        i_overload_done,
  input  wire        i_sys_idle,
  input  wire        i_sleeping,
  // Pins
  input  wire        i_bus_rx_pin,
  output reg         o_bus_tx_pin,
  output reg         o_bus_tx_oe,
  output reg         o_pins_own,
  // Engine controls
  output reg         o_eng_rx_bit,
  output reg         o_tx_allow,
  output reg         o_rx_allow,
  output reg         o_ack_allow,
  output reg         o_errflag_allow,
  output reg         o_err_cnt_run,
  output reg         o_err_cnt_clr,
  output reg         o_ignore_err,
  output reg         o_copy_partial,
  output reg         o_abort_all,
  output reg         o_abort_one,
  output reg         o_send_overload,
  output reg         o_capture_evt,
  output reg         o_window_filter,
  output reg         o_prot_wr_en,
  output reg         o_halted,
  output reg  [3:0]  o_id_bits_std,
  output reg  [4:0]  o_id_bits_ext
);

  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n = rst_s2_q;

  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  reg  [2:0]  req_q;
  reg  [2:0]  cur_q;
  reg         idle_stop_q;
  reg         abort_all_q;
  reg         caplink_q;
  reg         window_q;
  reg         wake_filt_en_q;
  reg         wake_flag_q;
  reg         aborted_q;
  reg  [3:0]  rec_cnt_q;
  reg         start_wait_q;
  reg  [1:0]  ovld_cnt_q;
  reg  [7:0]  wake_cnt_q;
  reg         filt_rx_q;
  reg         rx_prev_q;

  wire        halted   = idle_stop_q & i_sys_idle;
  wire        run      = i_clk_en & ~halted;
  wire        wr       = i_psel & i_penable & i_pwrite;
  wire        in_cfg   = (cur_q == `CMC_MODE_CONFIG);
  wire        bus_idle = (rec_cnt_q >= `CMC_IDLE_BITS);
  wire        offline  = (cur_q == `CMC_MODE_DISABLE) | in_cfg;
  wire        rx_src   = (cur_q == `CMC_MODE_LOOPBACK) ? i_eng_tx_bit : i_bus_rx_pin;
  wire        cfg_block = (req_q == `CMC_MODE_CONFIG) & i_tx_busy;
  wire [15:0] ctrl_rd;

  // Identifier widths sized to their output ports
  localparam [3:0] ID_STD_BITS = `CMC_BASE_ID_BITS;
  localparam [4:0] ID_EXT_BITS = `CMC_BASE_ID_BITS + `CMC_EXT_ID_BITS;

  function is_valid;
    input [2:0] m;
    begin
      is_valid = (m != 3'h5) && (m != 3'h6);
    end
  endfunction

  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign ctrl_rd   = {2'h0, idle_stop_q, abort_all_q, 1'b0, req_q, cur_q,
                      1'b0, caplink_q, 2'h0, window_q};

  // Bus idle detector and mode switcher
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_q          <= `CMC_MODE_CONFIG;
      cur_q          <= `CMC_MODE_CONFIG;
      idle_stop_q    <= 1'b0;
      abort_all_q    <= 1'b0;
      caplink_q      <= 1'b0;
      window_q       <= 1'b0;
      wake_filt_en_q <= 1'b0;
      wake_flag_q    <= 1'b0;
      aborted_q      <= 1'b0;
      rec_cnt_q      <= 4'h0;
      start_wait_q   <= 1'b0;
      ovld_cnt_q     <= 2'h0;
      wake_cnt_q     <= 8'h00;
      filt_rx_q      <= 1'b1;
      rx_prev_q      <= 1'b1;
    end
    else if (i_clk_en)
    begin
      // Register writes: control bits always writable
      if (wr && i_paddr == `CMC_ADDR_CTRL)
      begin
        if (is_valid(i_pwdata[`CMC_REQ_HI:`CMC_REQ_LO]))
          req_q <= i_pwdata[`CMC_REQ_HI:`CMC_REQ_LO];
        idle_stop_q <= i_pwdata[`CMC_IDLE_STOP_BIT];
        caplink_q   <= i_pwdata[`CMC_CAPLINK_BIT];
        window_q    <= i_pwdata[`CMC_WINDOW_BIT];
      end
      if (wr && i_paddr == `CMC_ADDR_CFG2 && in_cfg)
        wake_filt_en_q <= i_pwdata[`CMC_WAKE_FILT_BIT];
      // Abort-all: set by write, cleared when engine reports all aborted
      if (abort_all_q && i_all_aborted)
        abort_all_q <= 1'b0;
      if (wr && i_paddr == `CMC_ADDR_CTRL && i_pwdata[`CMC_ABORT_ALL_BIT])
        abort_all_q <= 1'b1;
      // Status: write one to clear, set wins
      if (wr && i_paddr == `CMC_ADDR_STATUS)
      begin
        if (i_pwdata[`CMC_ST_WAKE_BIT])
          wake_flag_q <= 1'b0;
        if (i_pwdata[`CMC_ST_ABORTED_BIT])
          aborted_q <= 1'b0;
      end
      // Wake filter on receive line while sleeping
      rx_prev_q <= i_bus_rx_pin;
      if (wake_filt_en_q && i_sleeping)
      begin
        if (i_bus_rx_pin == filt_rx_q)
          wake_cnt_q <= 8'h00;
        else if (wake_cnt_q == WAKE_FILT_LEN[7:0] - 8'h01)
        begin
          filt_rx_q  <= i_bus_rx_pin;
          wake_cnt_q <= 8'h00;
        end
        else
          wake_cnt_q <= wake_cnt_q + 8'h01;
      end
      else
      begin
        filt_rx_q  <= i_bus_rx_pin;
        wake_cnt_q <= 8'h00;
      end
      if (cur_q == `CMC_MODE_DISABLE && ((wake_filt_en_q && i_sleeping) ?
          (filt_rx_q == 1'b0) : (rx_prev_q & ~i_bus_rx_pin)))
        wake_flag_q <= 1'b1;
      if (!halted)
      begin
        if (i_bit_tick)
        begin
          if (!rx_src)
            rec_cnt_q <= 4'h0;
          else if (!bus_idle)
            rec_cnt_q <= rec_cnt_q + 4'h1;
        end
        if (i_tx_start && !offline)
          start_wait_q <= 1'b1;
        if (bus_idle)
          start_wait_q <= 1'b0;
        // Mode switch only at bus idle, latest request, config waits for tx
        if (bus_idle && req_q != cur_q && !cfg_block)
        begin
          cur_q <= req_q;
          if (req_q == `CMC_MODE_DISABLE && start_wait_q)
          begin
            aborted_q    <= 1'b1;
            start_wait_q <= 1'b0;
          end
        end
        // Overload frame count, cleared once interframe resumes normally
        if (i_overload_done && ovld_cnt_q != `CMC_MAX_OVERLOADS)
          ovld_cnt_q <= ovld_cnt_q + 2'h1;
        else if (i_tx_start || i_rx_msg_done)
          ovld_cnt_q <= 2'h0;
      end
    end
  end

  // Mode-dependent pin ownership and engine enables
  always @*
  begin
    o_pins_own      = 1'b0;
    o_bus_tx_oe     = 1'b0;
    o_tx_allow      = 1'b0;
    o_rx_allow      = 1'b0;
    o_ack_allow     = 1'b0;
    o_errflag_allow = 1'b0;
    o_err_cnt_run   = 1'b0;
    o_ignore_err    = 1'b0;
    o_copy_partial  = 1'b0;
    case (cur_q)
      `CMC_MODE_NORMAL:
      begin
        o_pins_own      = 1'b1;
        o_bus_tx_oe     = 1'b1;
        o_tx_allow      = ~start_wait_q | bus_idle;
        o_rx_allow      = 1'b1;
        o_ack_allow     = 1'b1;
        o_errflag_allow = 1'b1;
        o_err_cnt_run   = 1'b1;
      end
      `CMC_MODE_LISTEN:
      begin
        o_pins_own = 1'b1;
        o_rx_allow = 1'b1;
      end
      `CMC_MODE_LISTALL:
      begin
        o_pins_own     = 1'b1;
        o_rx_allow     = 1'b1;
        o_ignore_err   = 1'b1;
        o_copy_partial = i_rx_error;
      end
      `CMC_MODE_LOOPBACK:
      begin
        o_tx_allow      = ~start_wait_q | bus_idle;
        o_rx_allow      = 1'b1;
        o_ack_allow     = 1'b1;
        o_errflag_allow = 1'b1;
        o_err_cnt_run   = 1'b1;
      end
      `CMC_MODE_DISABLE:
        o_pins_own = 1'b0;
      `CMC_MODE_CONFIG:
        o_pins_own = 1'b0;
      default:
        o_pins_own = 1'b0;
    endcase
    if (halted)
    begin
      o_tx_allow = 1'b0;
      o_rx_allow = 1'b0;
    end
  end

  always @*
  begin
    o_bus_tx_pin    = o_bus_tx_oe ? i_eng_tx_bit : 1'b1;
    o_eng_rx_bit    = rx_src;
    o_err_cnt_clr   = in_cfg;
    o_abort_all     = abort_all_q;
    o_abort_one     = bus_idle && req_q == `CMC_MODE_DISABLE && cur_q != req_q
                      && start_wait_q && run;
    o_send_overload = (i_ifs_dominant | i_rx_not_ready) & o_rx_allow
                      & (ovld_cnt_q != `CMC_MAX_OVERLOADS);
    o_capture_evt   = caplink_q & i_rx_msg_done & o_rx_allow & i_clk_en;
    o_window_filter = window_q;
    o_prot_wr_en    = in_cfg;
    o_halted        = halted;
    o_id_bits_std   = ID_STD_BITS;
    o_id_bits_ext   = ID_EXT_BITS;
  end

  // Read data
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_prdata <= 32'h0000_0000;
    else if (i_clk_en && i_psel && !i_penable && !i_pwrite)
    begin
      case (i_paddr)
        `CMC_ADDR_CTRL:   o_prdata <= {16'h0000, ctrl_rd};
        `CMC_ADDR_CFG2:   o_prdata <= {17'h0, wake_filt_en_q, 14'h0};
        `CMC_ADDR_STATUS: o_prdata <= {24'h0, ovld_cnt_q, halted, i_tx_busy,
                                       bus_idle, i_tx_pending & ~aborted_q,
                                       aborted_q, wake_flag_q};
        `CMC_ADDR_PROT:   o_prdata <= {31'h0, in_cfg};
        default:          o_prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* sim/cmc_mode_ctrl_sva.sv */
module cmc_mode_ctrl_sva (
  input wire logic       i_core_clk, i_resetn, i_psel, i_pwrite, i_bit_tick,
  input wire logic       i_eng_tx_bit, i_all_aborted, i_rx_msg_done, i_rx_error,
  input wire logic       i_sys_idle, i_bus_rx_pin, o_pready, o_pslverr, o_bus_tx_pin,
  input wire logic       o_bus_tx_oe, o_pins_own, o_eng_rx_bit, o_tx_allow, o_rx_allow,
  input wire logic       o_ack_allow, o_errflag_allow, o_err_cnt_run, o_err_cnt_clr,
  input wire logic       o_ignore_err, o_copy_partial, o_abort_all, o_capture_evt,
  input wire logic       o_prot_wr_en, o_halted,
  input wire logic [3:0] o_id_bits_std,
  input wire logic [4:0] o_id_bits_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idle_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Recessive bit count on the engine's receive path, saturating at idle length
  always @(posedge i_core_clk or negedge i_resetn)
    if (!i_resetn || !o_eng_rx_bit)
      idle_q <= 4'h0;
    else if (i_bit_tick && idle_q != 4'hB)
      idle_q <= idle_q + 4'h1;
  sequence s_mode_move;
    $changed({o_tx_allow, o_rx_allow, o_pins_own, o_prot_wr_en}) && !$past(o_halted);
  endsequence
  sequence s_abort_done;
    o_abort_all && i_all_aborted && !(i_psel && i_pwrite);
  endsequence
  property p_mode_idle; s_mode_move |-> idle_q == 4'hB; endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode moved off idle");
  property p_pin_rel; !o_bus_tx_oe |-> o_bus_tx_pin; endproperty
  a_pin_rel: assert property (p_pin_rel) else $error("released pin not high");
  property p_cfg; o_prot_wr_en |-> o_err_cnt_clr && !o_tx_allow && !o_rx_allow; endproperty
  a_cfg: assert property (p_cfg) else $error("config not quiet");
  property p_listen;
    o_rx_allow && !o_tx_allow && !o_ignore_err |-> !(o_ack_allow || o_errflag_allow || o_err_cnt_run);
  endproperty
  a_listen: assert property (p_listen) else $error("listen not passive");
  property p_all; o_copy_partial == (o_ignore_err && i_rx_error); endproperty
  a_all: assert property (p_all) else $error("partial copy wrong");
  property p_loop; o_tx_allow && !o_pins_own |-> o_eng_rx_bit == i_eng_tx_bit; endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  property p_abort; s_abort_done |=> !o_abort_all; endproperty
  a_abort: assert property (p_abort) else $error("abort all not cleared");
  property p_halt; o_halted |-> i_sys_idle; endproperty
  a_halt: assert property (p_halt) else $error("halted outside idle");
  property p_cap; o_capture_evt |-> i_rx_msg_done; endproperty
  a_cap: assert property (p_cap) else $error("capture without message");
  property p_ids; o_id_bits_std == 4'hB && o_id_bits_ext == 5'h1D; endproperty
  a_ids: assert property (p_ids) else $error("identifier widths wrong");
  property p_apb; o_pready && !o_pslverr; endproperty
  a_apb: assert property (p_apb) else $error("bus answer wrong");
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_sva chk_u (.*);

/* sim/cmc_bus_node.sv */
module cmc_bus_node #(parameter int BT = 4) (
  input  wire logic i_clk,
  input  wire logic i_chatter,
  input  wire logic i_tx_pin,
  output logic      o_tick,
  output logic      o_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  logic       lvl_q = 1'b1;
  initial o_tick = 1'b0;
  always @(posedge i_clk)
  begin
    cnt_q <= (cnt_q == 8'(BT - 1)) ? 8'h00 : cnt_q + 8'h01;
    o_tick <= (cnt_q == 8'(BT - 1));
    // Other nodes talking never leave the bus idle
    if (cnt_q == 8'(BT - 1))
      lvl_q <= i_chatter ? !lvl_q : 1'b1;
  end
  // Wired-AND bus: a dominant bit from any node wins
  assign o_rx_pin = lvl_q & i_tx_pin;
endmodule

/* sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 4;
  logic i_core_clk, i_resetn, i_clk_en, i_psel, i_penable, i_pwrite, i_bit_tick, i_rx_bit;
  logic i_eng_tx_bit, i_tx_busy, i_tx_pending, i_tx_start, i_all_aborted, i_rx_msg_done;
  logic i_rx_error, i_ifs_dominant, i_rx_not_ready, i_overload_done, i_sys_idle, i_sleeping;
  logic i_bus_rx_pin, o_pready, o_pslverr, o_bus_tx_pin, o_bus_tx_oe, o_pins_own, o_eng_rx_bit;
  logic o_tx_allow, o_rx_allow, o_ack_allow, o_errflag_allow, o_err_cnt_run, o_err_cnt_clr;
  logic o_ignore_err, o_copy_partial, o_abort_all, o_abort_one, o_send_overload, o_capture_evt;
  logic o_window_filter, o_prot_wr_en, o_halted, chatter;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic [3:0]  o_id_bits_std;
  logic [4:0]  o_id_bits_ext;
  int          miscompares, n_checks;

  cmc_mode_ctrl #(.WAKE_FILT_LEN(2)) dut_u (.*);
  cmc_bus_node #(.BT(BT)) node_u (.i_clk(i_core_clk), .i_chatter(chatter),
    .i_tx_pin(o_bus_tx_pin), .o_tick(i_bit_tick), .o_rx_pin(i_bus_rx_pin));

  always #2.5 i_core_clk = !i_core_clk;

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rdat = o_prdata;
    {i_psel, i_penable} <= 2'b00;
  endtask

  task wctl(input logic [2:0] m, input logic [15:0] x);
    apb(1'b1, 12'h000, {16'h0, x | {5'h0, m, 8'h00}});
  endtask

  task go(input logic [2:0] m);
    wctl(m, 16'h0000);
    repeat (13 * BT) @(posedge i_core_clk);
    apb(1'b0, 12'h000, 32'h0);
  endtask

  task t_modes;
    logic [2:0] c;
    logic [2:0] p;
    p = 3'h4;
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 4) ? 3'h7 : (i == 5) ? 3'h4 : 3'(i);
      chatter <= 1'b1;
      repeat (2 * BT) @(posedge i_core_clk);
      go(c);
      // Loopback sees its own recessive transmit line, so it leaves at once
      chk("held", 32'(rdat[7:5]), 32'((p == 3'h2) ? c : p));
      chatter <= 1'b0;
      go(c);
      chk("mode", 32'(rdat[7:5]), 32'(c));
      if (c < 3'h3)
        chk("own", 32'(o_pins_own), 32'(c == 3'h0));
      if (c < 3'h4)
        chk("txen", 32'(o_tx_allow), 32'(c == 3'h0 || c == 3'h2));
      if (c == 3'h7)
      begin
        go(3'h5);
        chk("reserved", 32'(rdat[10:5]), 32'h3F);
      end
      p = c;
    end
  endtask

  task t_lock;
    apb(1'b1, 12'h004, 32'h4000);
    apb(1'b0, 12'h004, 32'h0);
    chk("cfg2", rdat, 32'h4000);
    go(3'h0);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("locked", rdat, 32'h4000);
    i_tx_busy <= 1'b1;
    go(3'h4);
    chk("busy", 32'(rdat[7:5]), 32'h0);
    i_tx_busy <= 1'b0;
    go(3'h4);
    chk("cfg", 32'(rdat[7:5]), 32'h4);
  endtask

  task t_replace;
    chatter <= 1'b1;
    repeat (2 * BT) @(posedge i_core_clk);
    wctl(3'h1, 16'h0000);
    chatter <= 1'b0;
    go(3'h3);
    chk("latest", 32'(rdat[7:5]), 32'h3);
    go(3'h4);
  endtask

  task t_misc;
    wctl(3'h4, 16'h1000);
    @(posedge i_core_clk);
    chk("abort set", 32'(o_abort_all), 32'h1);
    i_all_aborted <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk("abort clr", 32'(o_abort_all), 32'h0);
    i_all_aborted <= 1'b0;
    wctl(3'h4, 16'h2009);
    {i_sys_idle, i_rx_msg_done} <= 2'b11;
    {i_tx_pending, i_tx_start, i_ifs_dominant, i_overload_done, i_sleeping} <= 5'h1F;
    @(posedge i_core_clk);
    chk("halt", 32'(o_halted), 32'h1);
    chk("cfgcap", 32'(o_capture_evt), 32'h0);
    chk("win", 32'(o_window_filter), 32'h1);
    {i_tx_pending, i_tx_start, i_ifs_dominant, i_overload_done, i_sleeping} <= 5'h00;
    wctl(3'h4, 16'h0000);
    @(posedge i_core_clk);
    chk("run", 32'(o_halted), 32'h0);
    chk("nocap", 32'(o_capture_evt), 32'h0);
    chk("buf", 32'(o_window_filter), 32'h0);
    {i_sys_idle, i_rx_msg_done} <= 2'b00;
    wctl(3'h0, 16'h0008);
    repeat (13 * BT) @(posedge i_core_clk);
    i_rx_msg_done <= 1'b1;
    @(posedge i_core_clk);
    chk("cap", 32'(o_capture_evt), 32'h1);
    i_rx_msg_done <= 1'b0;
    @(posedge i_core_clk);
    chk("cap end", 32'(o_capture_evt), 32'h0);
  endtask

  task stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    {i_core_clk, i_resetn, i_clk_en, i_psel, i_penable, i_pwrite, i_rx_bit} = 7'h10;
    {i_eng_tx_bit, i_tx_busy, i_tx_pending, i_tx_start, i_all_aborted} = 5'h10;
    {i_rx_msg_done, i_rx_error, i_ifs_dominant, i_rx_not_ready} = 4'h0;
    {i_overload_done, i_sys_idle, i_sleeping, chatter} = 4'h0;
    {i_paddr, i_pwdata} = 44'h0;
    repeat (3) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("reset", rdat, 32'h0480);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", rdat, 32'h0);
    t_modes;
    t_lock;
    t_replace;
    t_misc;
    stop_test;
  end

  initial
  begin
    #60000;
    miscompares++;
    stop_test;
  end
endmodule
